// File: rtl/clk_supervisor_pkg.sv
/*
 Constants for the PLL watchdog and fractional clock generator block:
 register offsets, reset values, field layout, timing counts and the
 watchdog state type. Assumes a 40 MHz system clock.
*/
package clk_supervisor_pkg;
   // Register offsets on the control port
   localparam logic [15:0] WD_CTRL_ADDR = 16'hf006;
   localparam logic [15:0] GEN1_DEN_ADDR = 16'hf020;
   localparam logic [15:0] GEN1_NUM_ADDR = 16'hf021;
   localparam logic [15:0] GEN2_DEN_ADDR = 16'hf022;
   localparam logic [15:0] GEN2_NUM_ADDR = 16'hf023;
   localparam logic [15:0] GEN3_DEN_ADDR = 16'hf024;
   localparam logic [15:0] GEN3_NUM_ADDR = 16'hf025;
   localparam logic [15:0] GEN3_SRC_ADDR = 16'hf026;
   localparam logic [15:0] WD_STATUS_ADDR = 16'hf0f0;
   // Field layout
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int SMALL_W = 9;
   localparam int WD_EN_BIT = 0;
   localparam int GEN3_EXT_BIT = 4;
   localparam int PIN_SEL_W = 4;
   localparam int PIN_COUNT = 16;
   localparam int ACC_W = 17;
   localparam int EXT_ACC_W = 18;
   localparam int EVENT_W = 8;
   // Reset values
   localparam logic WD_EN_RST = 1'h1;
   localparam logic [8:0] GEN1_DEN_RST = 9'h006;
   localparam logic [8:0] GEN1_NUM_RST = 9'h001;
   localparam logic [8:0] GEN2_DEN_RST = 9'h009;
   localparam logic [8:0] GEN2_NUM_RST = 9'h001;
   localparam logic [15:0] GEN3_DEN_RST = 16'h0000;
   localparam logic [15:0] GEN3_NUM_RST = 16'h0000;
   localparam logic GEN3_EXT_RST = 1'h0;
   localparam logic [3:0] GEN3_PIN_RST = 4'he;
   // External reference scaling: output = fref * N / 1024
   localparam logic [16:0] EXT_SCALE = 17'h00400;
   // Timing: PLL reset pulse of at least 1000 ns at 40 MHz
   localparam int CLK_FREQ_KHZ = 40000;
   localparam int PLL_RST_NS = 1000;
   localparam int PLL_RST_CYCLES = (PLL_RST_NS * CLK_FREQ_KHZ + 999999) / 1000000;
   // Watchdog states
   typedef enum logic [1:0] {WD_WAIT_LOCK, WD_LOCKED, WD_RESETTING} wd_state_t;
endpackage

// File: rtl/clk_supervisor.sv
/*
 PLL watchdog and three fractional clock generators with their control
 registers. Assumes one 40 MHz system clock, a PLL lock level and up to
 sixteen reference pins arriving asynchronously, and a register master
 on the same clock that never issues read and write together.
*/
//
// Behaviour
// - Enabled watchdog resets PLL on instability
// - After reset PLL relocks, settings kept
// - Watchdog enable bit 0, resets to one
// - Gen1 denominator nine bits, resets six
// - Gen1 numerator nine bits, resets one
// - Gen2 denominator nine bits, resets nine
// - Gen2 numerator nine bits, resets one
// - Gen3 denominator sixteen bits, resets zero
// - Gen3 numerator sixteen bits, resets zero
// - Gen3 reference: PLL clock or external
// - External reference: rate fref*N/1024, M ignored
// - Four-bit pin select resets to receiver
`timescale 1ns/1ps
module clk_supervisor (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic srst_in,
   // Register port
   input wire logic [clk_supervisor_pkg::ADDR_W-1:0] addr_in,
   input wire logic [clk_supervisor_pkg::DATA_W-1:0] wr_data_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [clk_supervisor_pkg::DATA_W-1:0] rd_data_out,
   // PLL supervision
   input wire logic pll_lock_in,
   output logic pll_reset_out,
   // External references, multipurpose pins and receiver
   input wire logic [clk_supervisor_pkg::PIN_COUNT-1:0] ext_ref_in,
   // Base rate ticks of the three generators
   output logic gen1_tick_out,
   output logic gen2_tick_out,
   output logic gen3_tick_out
);
   import clk_supervisor_pkg::*;

   localparam logic [7:0] RST_LAST = 8'(PLL_RST_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////
   // State
   ////////////////////////////////////////////////////////////////////
   typedef struct packed {
      wd_state_t wd_state;
      logic [7:0] rst_cnt;
      logic [EVENT_W-1:0] wd_events;
      logic wd_en;
      logic [SMALL_W-1:0] gen1_denominator;
      logic [SMALL_W-1:0] gen1_numerator;
      logic [SMALL_W-1:0] gen2_denominator;
      logic [SMALL_W-1:0] gen2_numerator;
      logic [15:0] gen3_denominator;
      logic [15:0] gen3_numerator;
      logic gen3_external_ref_select;
      logic [PIN_SEL_W-1:0] gen3_ref_pin_select;
      logic lock_s1;
      logic lock_s2;
      logic [PIN_COUNT-1:0] ref_s1;
      logic [PIN_COUNT-1:0] ref_s2;
      logic [PIN_COUNT-1:0] ref_s3;
      logic [ACC_W-1:0] acc1;
      logic [ACC_W-1:0] acc2;
      logic [EXT_ACC_W-1:0] acc3;
      logic tick1;
      logic tick2;
      logic tick3;
      logic pll_rst;
      logic [DATA_W-1:0] rd_data;
   } state_t;

   state_t st_r;
   state_t st_nxt;

   ////////////////////////////////////////////////////////////////////
   // Helpers
   ////////////////////////////////////////////////////////////////////
   // One step of a rate divider: tick, remainder
   function automatic logic [ACC_W:0] frac_step(input logic [ACC_W-1:0] acc,
                                                 input logic [ACC_W-1:0] num,
                                                 input logic [ACC_W-1:0] den);
      logic [ACC_W:0] sum;
      sum = {1'b0, acc} + {1'b0, num};
      if (den == '0) begin
         // Zero denominator halts the generator
         frac_step = '0;
      end else if (num >= den) begin
         // Ratio of one or more saturates at a tick each cycle
         frac_step = {1'b1, {ACC_W{1'b0}}};
      end else if (sum >= {1'b0, den}) begin
         frac_step = {1'b1, ACC_W'(sum - {1'b0, den})};
      end else begin
         frac_step = {1'b0, sum[ACC_W-1:0]};
      end
   endfunction

   // Register read mux, unmapped offsets read zero
   function automatic logic [DATA_W-1:0] reg_read(input state_t s, input logic [ADDR_W-1:0] a);
      reg_read = '0;
      unique case (a)
         WD_CTRL_ADDR: reg_read[WD_EN_BIT] = s.wd_en;
         GEN1_DEN_ADDR: reg_read[SMALL_W-1:0] = s.gen1_denominator;
         GEN1_NUM_ADDR: reg_read[SMALL_W-1:0] = s.gen1_numerator;
         GEN2_DEN_ADDR: reg_read[SMALL_W-1:0] = s.gen2_denominator;
         GEN2_NUM_ADDR: reg_read[SMALL_W-1:0] = s.gen2_numerator;
         GEN3_DEN_ADDR: reg_read = s.gen3_denominator;
         GEN3_NUM_ADDR: reg_read = s.gen3_numerator;
         GEN3_SRC_ADDR: reg_read[GEN3_EXT_BIT:0] = {s.gen3_external_ref_select, s.gen3_ref_pin_select};
         WD_STATUS_ADDR: reg_read = {s.wd_events, 6'h00, s.pll_rst, s.lock_s2};
         default: reg_read = '0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Next state
   ////////////////////////////////////////////////////////////////////
   logic lock_now;
   logic ref_edge;
   logic [ACC_W:0] step1;
   logic [ACC_W:0] step2;
   logic [ACC_W:0] step3;
   logic [EXT_ACC_W-1:0] ext_sum;

   always_comb begin
      st_nxt = st_r;
      lock_now = st_r.lock_s2;
      ref_edge = st_r.ref_s2[st_r.gen3_ref_pin_select] & ~st_r.ref_s3[st_r.gen3_ref_pin_select];

      // Input synchronisers
      st_nxt.lock_s1 = pll_lock_in;
      st_nxt.lock_s2 = st_r.lock_s1;
      st_nxt.ref_s1 = ext_ref_in;
      st_nxt.ref_s2 = st_r.ref_s1;
      st_nxt.ref_s3 = st_r.ref_s2;

      // Register writes, reserved bits dropped
      if (wr_in) begin
         unique case (addr_in)
            WD_CTRL_ADDR: st_nxt.wd_en = wr_data_in[WD_EN_BIT];
            GEN1_DEN_ADDR: st_nxt.gen1_denominator = wr_data_in[SMALL_W-1:0];
            GEN1_NUM_ADDR: st_nxt.gen1_numerator = wr_data_in[SMALL_W-1:0];
            GEN2_DEN_ADDR: st_nxt.gen2_denominator = wr_data_in[SMALL_W-1:0];
            GEN2_NUM_ADDR: st_nxt.gen2_numerator = wr_data_in[SMALL_W-1:0];
            GEN3_DEN_ADDR: st_nxt.gen3_denominator = wr_data_in;
            GEN3_NUM_ADDR: st_nxt.gen3_numerator = wr_data_in;
            GEN3_SRC_ADDR: begin
               st_nxt.gen3_external_ref_select = wr_data_in[GEN3_EXT_BIT];
               st_nxt.gen3_ref_pin_select = wr_data_in[PIN_SEL_W-1:0];
            end
            default: begin
            end
         endcase
      end

      // Read data stands one cycle after the strobe only
      st_nxt.rd_data = rd_in ? reg_read(st_r, addr_in) : '0;

      // Watchdog; it never touches the generator settings
      unique case (st_r.wd_state)
         WD_WAIT_LOCK: begin
            if (lock_now) begin
               st_nxt.wd_state = WD_LOCKED;
            end
         end
         WD_LOCKED: begin
            // Disabled: a lost lock waits here until supervision returns
            if (!lock_now && st_r.wd_en) begin
               st_nxt.wd_state = WD_RESETTING;
               st_nxt.rst_cnt = RST_LAST;
               if (st_r.wd_events != '1) begin
                  st_nxt.wd_events = st_r.wd_events + 1'b1;
               end
            end
         end
         WD_RESETTING: begin
            if (st_r.rst_cnt == '0) begin
               st_nxt.wd_state = WD_WAIT_LOCK;
            end else begin
               st_nxt.rst_cnt = st_r.rst_cnt - 1'b1;
            end
         end
      endcase
      st_nxt.pll_rst = (st_nxt.wd_state == WD_RESETTING);

      // Generators 1 and 2 from the system clock
      step1 = frac_step(st_r.acc1, ACC_W'(st_r.gen1_numerator), ACC_W'(st_r.gen1_denominator));
      step2 = frac_step(st_r.acc2, ACC_W'(st_r.gen2_numerator), ACC_W'(st_r.gen2_denominator));
      st_nxt.tick1 = step1[ACC_W];
      st_nxt.acc1 = step1[ACC_W-1:0];
      st_nxt.tick2 = step2[ACC_W];
      st_nxt.acc2 = step2[ACC_W-1:0];

      // Generator 3 from the system clock or an external edge
      step3 = frac_step(st_r.acc3[ACC_W-1:0], ACC_W'(st_r.gen3_numerator), ACC_W'(st_r.gen3_denominator));
      ext_sum = st_r.acc3 + (ref_edge ? EXT_ACC_W'(st_r.gen3_numerator) : '0);
      if (st_r.gen3_external_ref_select) begin
         // Denominator unused; pending ticks drain one per cycle
         if (ext_sum >= EXT_ACC_W'(EXT_SCALE)) begin
            st_nxt.tick3 = 1'b1;
            st_nxt.acc3 = ext_sum - EXT_ACC_W'(EXT_SCALE);
         end else begin
            st_nxt.tick3 = 1'b0;
            st_nxt.acc3 = ext_sum;
         end
      end else begin
         st_nxt.tick3 = step3[ACC_W];
         st_nxt.acc3 = EXT_ACC_W'(step3[ACC_W-1:0]);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // State register
   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         st_r <= '0;
         st_r.wd_state <= WD_WAIT_LOCK;
         st_r.wd_en <= WD_EN_RST;
         st_r.gen1_denominator <= GEN1_DEN_RST;
         st_r.gen1_numerator <= GEN1_NUM_RST;
         st_r.gen2_denominator <= GEN2_DEN_RST;
         st_r.gen2_numerator <= GEN2_NUM_RST;
         st_r.gen3_denominator <= GEN3_DEN_RST;
         st_r.gen3_numerator <= GEN3_NUM_RST;
         st_r.gen3_external_ref_select <= GEN3_EXT_RST;
         st_r.gen3_ref_pin_select <= GEN3_PIN_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   assign rd_data_out = st_r.rd_data;
   assign pll_reset_out = st_r.pll_rst;
   assign gen1_tick_out = st_r.tick1;
   assign gen2_tick_out = st_r.tick2;
   assign gen3_tick_out = st_r.tick3;

   ////////////////////////////////////////////////////////////////////
   // Checks
   ////////////////////////////////////////////////////////////////////
   default clocking chk_cb @(posedge ref_clk_in);
   endclocking
   default disable iff (srst_in);

   // Length of the current reset pulse
   logic [7:0] pulse_len_r;
   always_ff @(posedge ref_clk_in) begin
      if (srst_in || !st_r.pll_rst) begin
         pulse_len_r <= '0;
      end else begin
         pulse_len_r <= pulse_len_r + 1'b1;
      end
   end

   sequence lock_lost_s;
      st_r.wd_state == WD_LOCKED && st_r.wd_en && !st_r.lock_s2;
   endsequence

   sequence pulse_start_s;
      pll_reset_out [*8];
   endsequence

   sequence cfg_stable_s;
      $stable(st_r.gen1_denominator) && $stable(st_r.gen1_numerator) && $stable(st_r.gen2_denominator)
         && $stable(st_r.gen2_numerator) && $stable(st_r.gen3_denominator) && $stable(st_r.gen3_numerator)
         && $stable(st_r.gen3_external_ref_select) && $stable(st_r.gen3_ref_pin_select);
   endsequence

   wd_trigger_a: assert property (lock_lost_s |=> pulse_start_s)
      else $error("PLL reset not raised after lock loss");

   wd_pulse_len_a: assert property ($fell(pll_reset_out) |-> $past(pulse_len_r) == 8'(PLL_RST_CYCLES - 1))
      else $error("PLL reset pulse length wrong");

   wd_disabled_a: assert property (!st_r.wd_en && st_r.wd_state == WD_LOCKED |=> !$rose(pll_reset_out))
      else $error("PLL reset raised while watchdog disabled");

   wd_relock_a: assert property ($fell(pll_reset_out) |-> st_r.wd_state == WD_WAIT_LOCK ##1 !pll_reset_out)
      else $error("Watchdog did not return to lock wait");

   cfg_keep_a: assert property (pll_reset_out && !wr_in |=> cfg_stable_s)
      else $error("Settings changed during PLL reset");

   reset_values_a: assert property ($past(srst_in) |-> st_r.wd_en && st_r.gen1_denominator == 9'h006
      && st_r.gen2_denominator == 9'h009 && st_r.gen2_numerator == 9'h001 && st_r.gen3_denominator == 16'h0000
      && st_r.gen3_ref_pin_select == 4'he)
      else $error("Register reset value wrong");

   rsvd_read_a: assert property (rd_in && addr_in == WD_CTRL_ADDR |=> rd_data_out[15:1] == '0)
      else $error("Reserved watchdog bits read non-zero");

   read_back_a: assert property (wr_in && addr_in == GEN3_NUM_ADDR ##1 rd_in && addr_in == GEN3_NUM_ADDR
      |=> rd_data_out == $past(wr_data_in, 2))
      else $error("Generator 3 numerator read back wrong");

   ratio_one_a: assert property (st_r.gen1_denominator != '0 && st_r.gen1_numerator >= st_r.gen1_denominator
      |=> gen1_tick_out)
      else $error("Generator 1 missed tick at full ratio");

   gen3_halt_a: assert property (!st_r.gen3_external_ref_select && st_r.gen3_denominator == '0 |=> !gen3_tick_out)
      else $error("Generator 3 ticked with zero denominator");

   ext_tick_a: assert property (st_r.gen3_external_ref_select && ext_sum >= EXT_ACC_W'(EXT_SCALE)
      |=> gen3_tick_out)
      else $error("Generator 3 missed external tick");

   ext_idle_a: assert property (st_r.gen3_external_ref_select && !ref_edge && st_r.acc3 < EXT_ACC_W'(EXT_SCALE)
      |=> !gen3_tick_out)
      else $error("Generator 3 ticked without reference");

   // Register writes land one cycle later, reserved bits dropped
   gen1_den_wr_a: assert property (wr_in && addr_in == GEN1_DEN_ADDR
      |=> st_r.gen1_denominator == SMALL_W'($past(wr_data_in)))
      else $error("Generator 1 denominator write lost");

   gen1_num_wr_a: assert property (wr_in && addr_in == GEN1_NUM_ADDR
      |=> st_r.gen1_numerator == SMALL_W'($past(wr_data_in)))
      else $error("Generator 1 numerator write lost");

   gen2_den_wr_a: assert property (wr_in && addr_in == GEN2_DEN_ADDR
      |=> st_r.gen2_denominator == SMALL_W'($past(wr_data_in)))
      else $error("Generator 2 denominator write lost");

   gen2_num_wr_a: assert property (wr_in && addr_in == GEN2_NUM_ADDR
      |=> st_r.gen2_numerator == SMALL_W'($past(wr_data_in)))
      else $error("Generator 2 numerator write lost");

   gen3_den_wr_a: assert property (wr_in && addr_in == GEN3_DEN_ADDR
      |=> st_r.gen3_denominator == $past(wr_data_in))
      else $error("Generator 3 denominator write lost");

   wd_hold_a: assert property (!st_r.wd_en && st_r.wd_state == WD_LOCKED
      |=> st_r.wd_state == WD_LOCKED)
      else $error("Lock loss forgotten while watchdog disabled");

endmodule

// File: verification/pll_model.sv
/*
 Behavioural PLL for the watchdog bench: locks a set number of cycles
 after its reset ends and loses lock on command.
 Assumes the bench clock and an active high PLL reset from the block.
*/
`timescale 1ns/1ps
module pll_model (
   // Clock and control
   input wire logic clk_in,
   input wire logic pll_reset_in,
   input wire logic unstable_in,
   input wire logic [7:0] lock_dly_in,
   // Lock level
   output logic lock_out
);
   logic [7:0] cnt_r = 8'h00;
   logic broken_r = 1'b0;
   ////////////////////////////////////////////////////////////////
   // Lock timer; an unstable PLL stays unlocked until it is reset
   always @(posedge clk_in) begin
      if (pll_reset_in) begin
         cnt_r <= 8'h00;
         broken_r <= 1'b0;
      end else if (unstable_in) begin
         broken_r <= 1'b1;
      end else if (cnt_r < lock_dly_in) begin
         cnt_r <= cnt_r + 8'h01;
      end
   end
   // Lock only when healthy, out of reset and timed out
   assign lock_out = !broken_r && !pll_reset_in && (cnt_r >= lock_dly_in);
endmodule

// File: verification/test_clk_supervisor.sv
/*
 Self-checking bench: register table, generator rates, watchdog, reset.
 Assumes the package and the pll_model partner.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_fail++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_clk_supervisor;
   import clk_supervisor_pkg::*;
   typedef struct {logic [15:0] addr; logic [15:0] rst; logic [15:0] wdata; logic [15:0] exp;} reg_row_t;
   typedef struct {logic [15:0] v[7]; int e[3];} rate_row_t;
   logic ref_clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic [15:0] addr_in = 16'h0000;
   logic [15:0] wr_data_in = 16'h0000;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [15:0] rd_data_out;
   logic pll_lock_in;
   logic pll_reset_out;
   logic unstable = 1'b0;
   logic [7:0] lock_dly = 8'h1e;
   logic [15:0] ext_ref_in = 16'h0000;
   logic [3:0] ref_cnt = 4'h0;
   logic gen1_tick_out;
   logic gen2_tick_out;
   logic gen3_tick_out;
   logic [15:0] rdv;
   int n_fail = 0;
   int num_checks = 0;
   int n;
   int c[3];
   logic [15:0] cfg_addr[7] = '{GEN1_NUM_ADDR, GEN1_DEN_ADDR, GEN2_NUM_ADDR, GEN2_DEN_ADDR,
      GEN3_NUM_ADDR, GEN3_DEN_ADDR, GEN3_SRC_ADDR};
   // Address, reset value, write value, readback
   reg_row_t regs[9] = '{
      '{WD_CTRL_ADDR, 16'h0001, 16'hffff, 16'h0001},
      '{GEN1_DEN_ADDR, 16'h0006, 16'hffff, 16'h01ff},
      '{GEN1_NUM_ADDR, 16'h0001, 16'hffff, 16'h01ff},
      '{GEN2_DEN_ADDR, 16'h0009, 16'hffff, 16'h01ff},
      '{GEN2_NUM_ADDR, 16'h0001, 16'hffff, 16'h01ff},
      '{GEN3_DEN_ADDR, 16'h0000, 16'hffff, 16'hffff},
      '{GEN3_NUM_ADDR, 16'h0000, 16'hffff, 16'hffff},
      '{GEN3_SRC_ADDR, 16'h000e, 16'hffff, 16'h001f},
      '{16'h1234, 16'h0000, 16'hffff, 16'h0000}};
   // Settings in cfg_addr order, ticks per 144 cycles
   rate_row_t rates[4] = '{
      '{'{16'hfe01, 16'h0006, 16'h0002, 16'h0009, 16'h0005, 16'h0010, 16'h000e}, '{24, 32, 45}},
      '{'{16'h0006, 16'h0006, 16'h0000, 16'h0009, 16'h0800, 16'h0010, 16'h001e}, '{144, 0, 36}},
      '{'{16'h0001, 16'h0006, 16'h0002, 16'h0009, 16'h0400, 16'h0000, 16'h0015}, '{24, 32, 9}},
      '{'{16'h0001, 16'h0006, 16'h0002, 16'h0009, 16'h0200, 16'h0010, 16'h0013}, '{24, 32, 0}}};
   ////////////////////////////////////////////////////////////////
   // 40 MHz clock
   always #12.5 ref_clk_in = ~ref_clk_in;
   // Square references: pin 14 every 8 cycles, pin 5 every 16
   always @(posedge ref_clk_in) begin
      ref_cnt <= ref_cnt + 4'h1;
      ext_ref_in <= {1'b0, ref_cnt[2], 8'h00, ref_cnt[3], 5'h00};
   end
   clk_supervisor DUT (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .addr_in(addr_in),
      .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
      .pll_lock_in(pll_lock_in), .pll_reset_out(pll_reset_out), .ext_ref_in(ext_ref_in),
      .gen1_tick_out(gen1_tick_out), .gen2_tick_out(gen2_tick_out), .gen3_tick_out(gen3_tick_out));
   pll_model PLL (.clk_in(ref_clk_in), .pll_reset_in(pll_reset_out), .unstable_in(unstable),
      .lock_dly_in(lock_dly), .lock_out(pll_lock_in));
   ////////////////////////////////////////////////////////////////
   // Bus cycles, waits and the verdict
   // Idle wait: both strobes drop right after the last transfer
   task cycles(input int k);
      wr_in <= 1'b0;
      rd_in <= 1'b0;
      repeat (k) @(posedge ref_clk_in);
      #1;
   endtask
   // Strobe stays up into a following transfer, one edge each
   task reg_wr(input logic [15:0] a, input logic [15:0] d);
      addr_in <= a;
      wr_data_in <= d;
      wr_in <= 1'b1;
      rd_in <= 1'b0;
      @(posedge ref_clk_in);
      #1;
   endtask
   task reg_rd(input logic [15:0] a, output logic [15:0] d);
      addr_in <= a;
      rd_in <= 1'b1;
      wr_in <= 1'b0;
      @(posedge ref_clk_in);
      #1;
      d = rd_data_out;
   endtask
   task report_and_stop;
      $display("checks=%0d mismatches=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Bounded wait on lock or PLL reset reaching a level
   task wait_sig(input bit use_lock, input logic want, input int bound, output int cnt);
      cnt = 0;
      while (((use_lock ? pll_lock_in : pll_reset_out) !== want) && cnt < bound) begin
         cycles(1);
         cnt++;
      end
      if (cnt >= bound) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, !want, want);
         report_and_stop();
      end
   endtask
   task count_ticks;
      c = '{0, 0, 0};
      repeat (144) begin
         cycles(1);
         c[0] += int'(gen1_tick_out === 1'b1);
         c[1] += int'(gen2_tick_out === 1'b1);
         c[2] += int'(gen3_tick_out === 1'b1);
      end
   endtask
   task lose_lock;
      unstable <= 1'b1;
      cycles(1);
      unstable <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (20) @(posedge ref_clk_in);
      srst_in <= 1'b0;
      cycles(2);
      foreach (regs[i]) begin
         reg_rd(regs[i].addr, rdv);
         `CHK(rdv, regs[i].rst)
         reg_wr(regs[i].addr, regs[i].wdata);
         reg_rd(regs[i].addr, rdv);
         `CHK(rdv, regs[i].exp)
      end
      $display("test register table done");
      foreach (rates[r]) begin
         for (int k = 0; k < 7; k++) begin
            reg_wr(cfg_addr[k], rates[r].v[k]);
         end
         cycles(150);
         count_ticks();
         for (int g = 0; g < 3; g++) begin
            `CHK(c[g], rates[r].e[g])
         end
      end
      $display("test generator rates done");
      // Lock loss under supervision: one 40-cycle reset, relock, settings kept
      wait_sig(1'b1, 1'b1, 100, n);
      lose_lock();
      wait_sig(1'b0, 1'b1, 12, n);
      `CHK(n <= 5, 1'b1)
      wait_sig(1'b0, 1'b0, 60, n);
      `CHK(n, 40)
      wait_sig(1'b1, 1'b1, 100, n);
      reg_rd(GEN3_SRC_ADDR, rdv);
      `CHK(rdv, 16'h0013)
      // Supervision off: no reset; back on: still-unlocked PLL is reset
      reg_wr(WD_CTRL_ADDR, 16'h0000);
      lock_dly <= 8'hc8;
      lose_lock();
      n = 0;
      repeat (60) begin
         cycles(1);
         n += int'(pll_reset_out === 1'b1);
      end
      `CHK(n, 0)
      reg_wr(WD_CTRL_ADDR, 16'h0001);
      wait_sig(1'b0, 1'b1, 12, n);
      `CHK(n <= 4, 1'b1)
      wait_sig(1'b0, 1'b0, 60, n);
      wait_sig(1'b1, 1'b1, 300, n);
      $display("test watchdog done");
      // Reset in mid-run restores register values
      reg_wr(WD_CTRL_ADDR, 16'h0000);
      reg_wr(GEN1_DEN_ADDR, 16'h0055);
      srst_in <= 1'b1;
      cycles(3);
      srst_in <= 1'b0;
      cycles(2);
      reg_rd(GEN1_DEN_ADDR, rdv);
      `CHK(rdv, 16'h0006)
      reg_rd(WD_CTRL_ADDR, rdv);
      `CHK(rdv, 16'h0001)
      $display("test mid-run reset done");
      report_and_stop();
   end
   // Overall limit on run length
   initial begin
      #2500000;
      n_fail++;
      report_and_stop();
   end
endmodule
